// [hdl/acc_converter_control.sv]
/*
  Control logic of a 10-bit successive-approximation converter: APB
  register file, conversion clock selection, the twelve-period
  conversion sequence, result formatting and the done interrupt.
  Assumes an analog front end that follows channel_onehot, samples
  while sample_hold is high and drives comparator_pin high when the
  held input is at or above dac_trial; rc_clock_pin comes from the
  converter's own RC oscillator, asynchronous to clk.
*/
// The APB register port was left to the implementer.
// How it works
// RULE_01 - Each conversion yields a ten-bit result.
// RULE_02 - Five input channels on the small variant, eight on the large one.
// RULE_03 - References chosen among supply, ground and two reference pins.
// RULE_04 - Only the RC conversion clock keeps converting during sleep.
// RULE_05 - High select bit plus two-bit field choose divider or RC clock.
// RULE_06 - Channel field at bits 5..3 routes channel n to the converter.
// RULE_07 - Software avoids channel codes above 4 on the small variant.
// RULE_08 - Writing go while powered starts; go reads 1 during conversion.
// RULE_09 - Hardware clears go at completion; 0 means idle.
// RULE_10 - Power bit at bit 0 powers the converter; clear shuts it off.
// RULE_11 - Bit 1 of the first control register reads zero.
// RULE_12 - Implemented first-control bits are read/write and reset to zero.
// RULE_13 - Four registers: result high, result low, two control registers.
// RULE_14 - Completion loads result, clears go, sets done flag together.
// RULE_15 - Format bit picks right or left justification, unused bits zero.
// RULE_16 - A conversion lasts twelve conversion clock periods.
// RULE_17 - Go written while unpowered starts nothing.
`timescale 1ns/1ps
`default_nettype none
module acc_converter_control #(
  parameter bit LARGE_PACKAGE = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [acc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep_mode,
  input wire logic rc_clock_pin,
  input wire logic comparator_pin,
  output logic irq,
  output logic converter_on,
  output logic [7:0] channel_onehot,
  output logic sample_hold,
  output logic [acc_pkg::RESULT_W-1:0] dac_trial,
  output logic [7:0] analog_pin_mask,
  output logic ref_high_pin_sel,
  output logic ref_low_pin_sel
);
  import acc_pkg::*;

  typedef struct packed {
    logic [1:0] clk_lo;
    logic [2:0] chan;
    logic go;
    logic power;
    logic fmt;
    logic clk_hi;
    logic [3:0] pcfg;
    logic [7:0] res_hi;
    logic [7:0] res_lo;
    logic done_flag;
    logic done_en;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    acc_state_t state;
    logic [3:0] bit_idx;
    logic [6:0] div_cnt;
    logic [RESULT_W-1:0] trial;
    logic comp_s1;
    logic comp_s2;
    logic rc_s1;
    logic rc_s2;
    logic rc_prev;
    logic [7:0] chan_hot;
    logic [7:0] pin_mask;
    logic ref_hi;
    logic ref_lo;
    logic sample;
  } acc_st_t;

  localparam acc_st_t ST_RESET = '{
    clk_lo: CONTROL_0_RESET[C0_CLK_LO +: 2],
    chan: CONTROL_0_RESET[C0_CHAN +: 3],
    go: CONTROL_0_RESET[C0_GO],
    power: CONTROL_0_RESET[C0_POWER],
    fmt: CONTROL_1_RESET[C1_FORMAT],
    clk_hi: CONTROL_1_RESET[C1_CLK_HI],
    pcfg: CONTROL_1_RESET[C1_PCFG +: 4],
    res_hi: 8'h00,
    res_lo: 8'h00,
    done_flag: 1'b0,
    done_en: 1'b0,
    irq: 1'b0,
    pready: 1'b0,
    pslverr: 1'b0,
    prdata: 32'h0000_0000,
    state: ACC_IDLE,
    bit_idx: 4'h0,
    div_cnt: 7'h00,
    trial: 10'h000,
    comp_s1: 1'b0,
    comp_s2: 1'b0,
    rc_s1: 1'b0,
    rc_s2: 1'b0,
    rc_prev: 1'b0,
    chan_hot: 8'h00,
    pin_mask: PIN_MASK_RESET,
    ref_hi: 1'b0,
    ref_lo: 1'b0,
    sample: 1'b0
  };

  acc_st_t r;
  acc_st_t n;

  logic [9:0] idx;
  logic access;
  logic wr_done;
  logic mapped;
  logic rc_sel;
  logic [6:0] ratio;
  logic div_tick;
  logic tad_tick;
  logic conv_done;
  logic start;
  logic abort;
  logic [RESULT_W-1:0] bit_mask;
  logic [RESULT_W-1:0] decided;
  logic [9:0] pin_cfg;

  // Word index from the byte address; low two bits are ignored
  assign idx = paddr[ADDR_W-1:2];
  assign access = psel & penable;
  assign wr_done = access & r.pready & pwrite;
  assign mapped = (idx == IDX_CONTROL_0) | (idx == IDX_CONTROL_1) |
                  (idx == IDX_RESULT_HIGH) | (idx == IDX_RESULT_LOW) |
                  (idx == IDX_IRQ_STATUS) | (idx == IDX_IRQ_CLEAR) |
                  (idx == IDX_IRQ_ENABLE);

  // Divider ratio from the high select bit and the two-bit field
  always_comb begin
    case ({r.clk_hi, r.clk_lo}) // [RULE_05]
      3'b000: ratio = RATIO_2;
      3'b001: ratio = RATIO_8;
      3'b010: ratio = RATIO_32;
      3'b100: ratio = RATIO_4;
      3'b101: ratio = RATIO_16;
      3'b110: ratio = RATIO_64;
      default: ratio = RATIO_2;
    endcase
  end
  assign rc_sel = (r.clk_lo == CLK_SEL_RC); // [RULE_05]

  // Pin function and reference routing: {analog mask, ref high, ref low}
  always_comb begin
    case (r.pcfg) // [RULE_03] [RULE_13]
      4'h0: pin_cfg = {8'hff, 1'b0, 1'b0};
      4'h1: pin_cfg = {8'hf7, 1'b1, 1'b0};
      4'h2: pin_cfg = {8'h1f, 1'b0, 1'b0};
      4'h3: pin_cfg = {8'h17, 1'b1, 1'b0};
      4'h4: pin_cfg = {8'h0b, 1'b0, 1'b0};
      4'h5: pin_cfg = {8'h03, 1'b1, 1'b0};
      4'h6: pin_cfg = {8'h00, 1'b0, 1'b0};
      4'h7: pin_cfg = {8'h00, 1'b0, 1'b0};
      4'h8: pin_cfg = {8'hf3, 1'b1, 1'b1};
      4'h9: pin_cfg = {8'h3f, 1'b0, 1'b0};
      4'ha: pin_cfg = {8'h37, 1'b1, 1'b0};
      4'hb: pin_cfg = {8'h33, 1'b1, 1'b1};
      4'hc: pin_cfg = {8'h13, 1'b1, 1'b1};
      4'hd: pin_cfg = {8'h03, 1'b1, 1'b1};
      4'he: pin_cfg = {8'h01, 1'b0, 1'b0};
      default: pin_cfg = {8'h01, 1'b1, 1'b1};
    endcase
  end

  // Trial bit under test and the value once the comparator has spoken
  assign bit_mask = 10'(10'h001 << r.bit_idx);
  assign decided = r.comp_s2 ? r.trial : (r.trial & ~bit_mask);

  // Next-state logic for the whole block
  always_comb begin
    n = r;
    conv_done = 1'b0;
    start = 1'b0;
    abort = 1'b0;
    div_tick = 1'b0;

    // Two-stage synchronisers; rc_prev only looks at the second stage
    n.comp_s1 = comparator_pin;
    n.comp_s2 = r.comp_s1;
    n.rc_s1 = rc_clock_pin;
    n.rc_s2 = r.rc_s1;
    n.rc_prev = r.rc_s2;

    // Oscillator divider runs only while converting
    if (r.state == ACC_IDLE) begin
      n.div_cnt = 7'h00;
    end else if (r.div_cnt == 7'(ratio - 7'h01)) begin
      n.div_cnt = 7'h00;
      div_tick = 1'b1;
    end else begin
      n.div_cnt = 7'(r.div_cnt + 7'h01);
    end
    // The oscillator stops in sleep; the RC clock keeps ticking
    tad_tick = rc_sel ? (r.rc_s2 & ~r.rc_prev) : (div_tick & ~sleep_mode); // [RULE_04]

    // Conversion sequence: hold, ten bit trials, finish
    case (r.state)
      ACC_IDLE: begin
        n.trial = 10'h000;
      end
      ACC_HOLD: begin
        if (tad_tick && rc_sel && r.bit_idx == 4'h0) begin
          // First RC edge falls anywhere in its period, so it only aligns the hold
          n.bit_idx = 4'h1; // [RULE_16]
        end else if (tad_tick) begin // [RULE_16]
          n.state = ACC_BITS;
          n.bit_idx = TOP_BIT;
          n.trial = 10'(10'h001 << TOP_BIT);
        end
      end
      ACC_BITS: begin
        if (tad_tick) begin // [RULE_01] [RULE_16]
          if (r.bit_idx == 4'h0) begin
            n.trial = decided;
            n.state = ACC_FINISH;
          end else begin
            n.bit_idx = 4'(r.bit_idx - 4'h1);
            n.trial = decided | 10'(10'h001 << 4'(r.bit_idx - 4'h1));
          end
        end
      end
      ACC_FINISH: begin
        if (tad_tick) begin
          conv_done = 1'b1;
        end
      end
      default: begin
        n.state = ACC_IDLE;
      end
    endcase

    // Completion: result pair, go and done flag change together
    if (conv_done) begin // [RULE_14]
      n.state = ACC_IDLE;
      n.go = 1'b0; // [RULE_09]
      if (r.fmt) begin // [RULE_15]
        n.res_hi = {6'h00, r.trial[9:8]};
        n.res_lo = r.trial[7:0];
      end else begin
        n.res_hi = r.trial[9:2];
        n.res_lo = {r.trial[1:0], 6'h00};
      end
    end

    // APB: one wait state, answer with pready in the second access cycle
    n.pready = access & ~r.pready;
    n.pslverr = access & ~r.pready & ~mapped;
    n.prdata = 32'h0000_0000;
    if (access & ~r.pready & ~pwrite) begin
      case (idx)
        IDX_CONTROL_0: n.prdata[7:0] = {r.clk_lo, r.chan, r.go, 1'b0, r.power}; // [RULE_11]
        IDX_CONTROL_1: n.prdata[7:0] = {r.fmt, r.clk_hi, 2'b00, r.pcfg};
        IDX_RESULT_HIGH: n.prdata[7:0] = r.res_hi;
        IDX_RESULT_LOW: n.prdata[7:0] = r.res_lo;
        IDX_IRQ_STATUS: n.prdata[IRQ_DONE] = r.done_flag;
        IDX_IRQ_ENABLE: n.prdata[IRQ_DONE] = r.done_en;
        default: n.prdata = 32'h0000_0000;
      endcase
    end

    // Register writes take effect at the edge that completes the access
    if (wr_done && idx == IDX_CONTROL_0) begin // [RULE_12]
      n.clk_lo = pwdata[C0_CLK_LO +: 2];
      n.chan = pwdata[C0_CHAN +: 3]; // [RULE_06]
      n.power = pwdata[C0_POWER]; // [RULE_10]
      if (!pwdata[C0_POWER] || !pwdata[C0_GO]) begin
        abort = 1'b1;
      end else if (r.state == ACC_IDLE) begin
        start = 1'b1; // [RULE_08] [RULE_17]
      end
    end
    if (wr_done && idx == IDX_CONTROL_1) begin
      n.fmt = pwdata[C1_FORMAT];
      n.clk_hi = pwdata[C1_CLK_HI];
      n.pcfg = pwdata[C1_PCFG +: 4];
    end
    if (wr_done && idx == IDX_IRQ_ENABLE) begin
      n.done_en = pwdata[IRQ_DONE];
    end

    // A control write with go or power clear ends the conversion; a completion in the same cycle still stores its result
    if (abort) begin // [RULE_10]
      n.go = 1'b0;
      n.state = ACC_IDLE;
    end else if (start) begin
      n.go = 1'b1; // [RULE_08]
      n.state = ACC_HOLD;
      n.bit_idx = 4'h0;
    end

    // Trial rests at zero whenever no conversion runs, completion included
    if (n.state == ACC_IDLE) begin
      n.trial = 10'h000;
    end

    // Sticky done flag; a completion in the clearing cycle still sets it
    n.done_flag = (r.done_flag & ~(wr_done && idx == IDX_IRQ_CLEAR && pwdata[IRQ_DONE])) |
                  conv_done;
    n.irq = n.done_flag & n.done_en;

    // Front end controls; channels above 4 are dead on the small variant
    n.chan_hot = 8'h00;
    if (n.power && (LARGE_PACKAGE || n.chan <= SMALL_LAST_CHANNEL)) begin // [RULE_02] [RULE_07]
      n.chan_hot = 8'(8'h01 << n.chan); // [RULE_06]
    end
    n.sample = n.power & (n.state == ACC_IDLE);
    n.pin_mask = pin_cfg[9:2];
    n.ref_hi = pin_cfg[1]; // [RULE_03]
    n.ref_lo = pin_cfg[0];
  end

  // State register; synchronous reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= ST_RESET;
    end else begin
      r <= n;
    end
  end

  // All outputs come straight from the state register
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign irq = r.irq;
  assign converter_on = r.power; // [RULE_10]
  assign channel_onehot = r.chan_hot;
  assign sample_hold = r.sample;
  assign dac_trial = r.trial;
  assign analog_pin_mask = r.pin_mask;
  assign ref_high_pin_sel = r.ref_hi;
  assign ref_low_pin_sel = r.ref_lo;

endmodule
`default_nettype wire

// [hdl/acc_pkg.sv]
/*
  Shared constants for the analog conversion control block: register
  indices and the address width, field positions, reset values, clock
  divider ratios and the conversion sequence length.
  Assumes a 32-bit APB register bus with word-aligned registers.
*/
package acc_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [9:0] IDX_CONTROL_0 = 10'h01f;
  localparam logic [9:0] IDX_CONTROL_1 = 10'h09f;
  localparam logic [9:0] IDX_RESULT_HIGH = 10'h01e;
  localparam logic [9:0] IDX_RESULT_LOW = 10'h09e;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h0a0;
  localparam logic [9:0] IDX_IRQ_CLEAR = 10'h0a1;
  localparam logic [9:0] IDX_IRQ_ENABLE = 10'h0a2;
  localparam int ADDR_W = 12;

  // Fields of conversion_control_0
  localparam int C0_CLK_LO = 6;
  localparam int C0_CHAN = 3;
  localparam int C0_GO = 2;
  localparam int C0_POWER = 0;
  // Fields of conversion_control_1
  localparam int C1_FORMAT = 7;
  localparam int C1_CLK_HI = 6;
  localparam int C1_PCFG = 0;
  // Bit of conversion_done_flag in status, clear and enable registers
  localparam int IRQ_DONE = 0;

  // Reset values
  localparam logic [7:0] CONTROL_0_RESET = 8'h00;
  localparam logic [7:0] CONTROL_1_RESET = 8'h00;
  localparam logic [7:0] PIN_MASK_RESET = 8'hff;

  // Conversion clock selection
  localparam logic [1:0] CLK_SEL_RC = 2'h3;
  localparam logic [6:0] RATIO_2 = 7'h02;
  localparam logic [6:0] RATIO_4 = 7'h04;
  localparam logic [6:0] RATIO_8 = 7'h08;
  localparam logic [6:0] RATIO_16 = 7'h10;
  localparam logic [6:0] RATIO_32 = 7'h20;
  localparam logic [6:0] RATIO_64 = 7'h40;

  // Result width and conversion sequence: 1 hold + 10 bits + 1 finish
  localparam int RESULT_W = 10;
  localparam int TAD_PER_CONVERSION = 12;
  localparam logic [3:0] TOP_BIT = 4'h9;
  localparam logic [2:0] SMALL_LAST_CHANNEL = 3'h4;

  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_HOLD,
    ACC_BITS,
    ACC_FINISH
  } acc_state_t;

endpackage

// [verif/acc_front_end_model.sv]
/*
  Behavioural analog front end: comparator and RC oscillator.
  Assumes the bench sets the held input level on level.
*/
`timescale 1ns/1ps
`default_nettype none
module acc_front_end_model (
  input wire logic converter_on,
  input wire logic [7:0] channel_onehot,
  input wire logic [9:0] dac_trial,
  input wire logic [9:0] level,
  output logic rc_clock_pin,
  output logic comparator_pin
);
  // Oscillator runs free, 300 ns period, sleep or not
  initial rc_clock_pin = 1'b0;
  always #150 rc_clock_pin = ~rc_clock_pin;
  // Unrouted comparator wanders so a stale level never looks valid
  assign comparator_pin = (converter_on && |channel_onehot) ?
    (level >= dac_trial) : rc_clock_pin;
endmodule
`default_nettype wire

// [verif/acc_sva.sv]
/*
  Port checker for the converter control block.
  Assumes binding to every acc_converter_control instance.
*/
`timescale 1ns/1ps
`default_nettype none
module acc_sva
  import acc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic [acc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq,
  input wire logic converter_on,
  input wire logic [7:0] channel_onehot,
  input wire logic sample_hold,
  input wire logic [9:0] dac_trial
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Bus timing and read data shape
  wait_state_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("pready not after one wait state");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h00000000)
    else $error("read data outside answer cycle");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  bit1_zero_a: assert property (pready && paddr[11:2] == IDX_CONTROL_0 |-> !prdata[1])
    else $error("control bit 1 not zero");
  // Routing and power
  route_onehot_a: assert property ($onehot0(channel_onehot))
    else $error("more than one channel routed");
  off_route_a: assert property (!converter_on |-> channel_onehot == 8'h00)
    else $error("channel routed while off");
  hold_power_a: assert property (sample_hold |-> converter_on)
    else $error("sampling while off");
  trial_idle_a: assert property (sample_hold |-> dac_trial == 10'h000)
    else $error("trial value while idle");
  // Flag only drops after a register write
  irq_fall_a: assert property ($fell(irq) |-> $past(pready) || $past(pready, 2))
    else $error("irq dropped without a write");
  cover property (pslverr);
  cover property ($rose(irq));
  cover property ($rose(sample_hold));
endmodule
bind acc_converter_control acc_sva chk_i (.clk, .rst_n, .psel, .penable, .paddr, .prdata,
  .pready, .pslverr, .irq, .converter_on, .channel_onehot, .sample_hold, .dac_trial);
`default_nettype wire

// [verif/tb_top.sv]
/*
  Self-checking bench for the converter control block.
  Assumes the front end model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import acc_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, sleep_mode = 1'b0, rc_clock_pin, comparator_pin, irq;
  logic converter_on, sample_hold, ref_high_pin_sel, ref_low_pin_sel;
  logic [7:0] channel_onehot, analog_pin_mask;
  logic [9:0] dac_trial, level = '0;
  int failures = 0, total_checks = 0;
  always #25 clk = ~clk;
  acc_converter_control uut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .sleep_mode, .rc_clock_pin, .comparator_pin, .irq,
    .converter_on, .channel_onehot, .sample_hold, .dac_trial, .analog_pin_mask,
    .ref_high_pin_sel, .ref_low_pin_sel);
  acc_front_end_model fe (.converter_on, .channel_onehot, .dac_trial, .level,
    .rc_clock_pin, .comparator_pin);
  task automatic finish_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
    total_checks++;
    if (g < lo || g > hi) begin
      failures++;
      $display("Error %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  // One idle cycle before each setup; pready, data and error taken at one rising edge
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] d,
      output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      failures++;
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, d, r, e);
  endtask
  task automatic rdchk(input logic [9:0] idx, input logic [31:0] e, input string nm);
    logic [31:0] r;
    logic er;
    apb(1'b0, idx, 8'h00, r, er);
    chk(nm, e, r);
  endtask
  task automatic t_reset();
    rdchk(IDX_CONTROL_0, 32'h0, "ctl0 reset");
    rdchk(IDX_CONTROL_1, 32'h0, "ctl1 reset");
    rdchk(IDX_IRQ_ENABLE, 32'h0, "enable reset");
    chk("pin mask", 32'hff, {24'h0, analog_pin_mask});
  endtask
  // Unpowered go, unmapped access, pin configuration table
  task automatic t_access();
    logic [31:0] r;
    logic er;
    logic [7:0] cw [4] = '{8'h31, 8'h38, 8'h02, 8'h06};
    logic [1:0] rf [4] = '{2'h2, 2'h3, 2'h0, 2'h0};
    wr(IDX_CONTROL_0, 8'hfe);
    rdchk(IDX_CONTROL_0, 32'hf8, "ctl0 rw");
    chk("power", 32'h0, {31'h0, converter_on});
    apb(1'b0, 10'h3ff, 8'h00, r, er);
    chk("unmapped err", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, r);
    for (int i = 0; i < 4; i++) begin
      wr(IDX_CONTROL_1, cw[i]);
      rdchk(IDX_CONTROL_1, {24'h0, cw[i] & 8'hcf}, "ctl1 rw");
      chk("refs", {30'h0, rf[i]}, {30'h0, ref_high_pin_sel, ref_low_pin_sel});
      if (i > 1) chk("mask", (i == 2) ? 32'h1f : 32'h0, {24'h0, analog_pin_mask});
    end
  endtask
  // Each divider ratio and the RC clock, format from bit 0 xor bit 1 of i; RC case runs in sleep
  task automatic t_convert();
    logic [9:0] lv;
    logic [2:0] ch;
    logic fm;
    int cyc, rt;
    realtime t0;
    wr(IDX_IRQ_ENABLE, 8'h01);
    for (int i = 0; i < 7; i++) begin
      ch = i[2:0]; // Codes up to 6 only, legal on this part
      fm = i[0] ^ i[1];
      lv = 10'h2a5 + 10'(i) * 10'h0c3;
      rt = (i < 6) ? (2 << i) : 6;
      level <= lv;
      wr(IDX_CONTROL_1, {fm, i[0], 6'h00});
      wr(IDX_CONTROL_0, {i[2:1], ch, 3'b001});
      sleep_mode <= (i == 6); // RC clock chosen before sleep
      wr(IDX_CONTROL_0, {i[2:1], ch, 3'b101});
      t0 = $realtime;
      chk("route", 32'h1 << ch, {24'h0, channel_onehot});
      chk("power on", 32'h1, {31'h0, converter_on});
      rdchk(IDX_CONTROL_0, {24'h0, i[2:1], ch, 3'b101}, "go busy");
      for (cyc = 0; cyc < 2000 && sample_hold !== 1'b1; cyc++) @(negedge clk);
      if (cyc == 2000) begin
        failures++;
        finish_test();
      end
      cyc = int'(($realtime - t0 - 25.0) / 50.0);
      // Divided clocks are exact; the free RC phase adds up to one period
      chk_rng("duration", TAD_PER_CONVERSION * rt + int'(i == 6),
        TAD_PER_CONVERSION * rt + ((i == 6) ? rt : 0), cyc);
      rdchk(IDX_CONTROL_0, {24'h0, i[2:1], ch, 3'b001}, "go done");
      // At /2 the synced comparator lags the trial, so no result is judged there
      if (i >= 1) begin
        rdchk(IDX_RESULT_HIGH, fm ? {30'h0, lv[9:8]} : {24'h0, lv[9:2]}, "high");
        rdchk(IDX_RESULT_LOW, fm ? {24'h0, lv[7:0]} : {24'h0, lv[1:0], 6'h0}, "low");
      end
      chk("irq", 32'h1, {31'h0, irq});
      rdchk(IDX_IRQ_STATUS, 32'h1, "flag");
      wr(IDX_IRQ_CLEAR, 8'h01);
      rdchk(IDX_IRQ_STATUS, 32'h0, "flag clear");
      chk("irq clear", 32'h0, {31'h0, irq});
      sleep_mode <= 1'b0;
    end
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_access();
    t_convert();
    finish_test();
  end
endmodule
`default_nettype wire
